// [hw/ctb_pkg.sv]
// constants, types and register map of the chained timebase block
// assumes a 25 MHz ref_clk and a 400 ns chain timebase period
package ctb_pkg;
   localparam int          CLK_PERIOD_NS = 40;
   localparam int          TB_PERIOD_NS  = 400;
   localparam int          TB_CYCLES     = TB_PERIOD_NS / CLK_PERIOD_NS;
   localparam int          TB_HALF       = TB_CYCLES / 2;
   localparam int          ABSENT_NS     = 1600;
   localparam int          ABSENT_CYCLES = ABSENT_NS / CLK_PERIOD_NS;
   localparam logic [31:0] NS_STEP       = 32'h0000_0190;
   localparam logic [31:0] NS_PER_SEC    = 32'h3B9A_CA00;
   localparam int          FRAME_BITS    = 64;
   localparam int          AW            = 12;
   localparam logic [AW-1:0] OFF_TICK_HI  = 12'h000;
   localparam logic [AW-1:0] OFF_TICK_LO  = 12'h008;
   localparam logic [AW-1:0] OFF_TICK_ST  = 12'h010;
   localparam logic [AW-1:0] OFF_TOD_SEC  = 12'h100;
   localparam logic [AW-1:0] OFF_TOD_NS   = 12'h108;
   localparam logic [AW-1:0] OFF_TOD_ST   = 12'h110;
   localparam logic [AW-1:0] OFF_CHAIN    = 12'h200;
   localparam logic [AW-1:0] OFF_TICK_CTL = 12'h204;
   localparam logic [AW-1:0] OFF_TOD_CTL  = 12'h208;
   localparam logic [AW-1:0] OFF_RX_SEC   = 12'h210;
   localparam logic [AW-1:0] OFF_RX_NS    = 12'h214;
   localparam logic [AW-1:0] OFF_RX_ST    = 12'h218;
   // chain control word bits
   localparam int          CH_EN_BIT     = 2;
   localparam int          CH_SYNC_BIT   = 3;
   localparam int          CH_REFUSE_BIT = 8;
   // status word bits above the four control bits
   localparam int          ST_FOLLOW_BIT = 4;
   localparam int          ST_CABLE_BIT  = 8;
   localparam int          ST_ABSENT_BIT = 9;
   localparam int          ST_STOP_BIT   = 10;
   localparam int          ST_ROLE_LSB   = 12;
   typedef enum logic [1:0] {
      ROLE_MASTER = 2'h0, ROLE_PASS = 2'h1, ROLE_FINAL = 2'h2, ROLE_ISOLATED = 2'h3
   } ctb_role_e;
   typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_START = 2'h1, TX_DATA = 2'h2} ctb_tx_e;
   // per-clock control: hold when stopped, follow cable, clear on sync, enable
   typedef struct packed {
      logic hold;
      logic follow;
      logic clrOnSync;
      logic enable;
   } ctb_clk_ctrl_s;
   typedef struct packed {
      logic clk;
      logic run;
      logic sync;
      logic data;
   } ctb_cable_s;
   localparam ctb_clk_ctrl_s CTRL_RESET = 4'h1;
endpackage

// [hw/ctb_timebase.sv]
// chained timebase: tick counter and seconds/nanoseconds clock on a cable chain
// assumes cable inputs are asynchronous to ref_clk and a plain strobe register port
//
// What this block does
// - 64-bit tick counter adds one per 400 ns timebase period.
// - time-of-day clock holds seconds high, nanoseconds low.
// - time-of-day clock advances on the same timebase as the tick counter.
// - slave clocks set to follow the cable advance from the master's forwarded timebase.
// - tick counter cannot be loaded; only counts or clears to zero.
// - slave tick counter clears and counts in step with the master.
// - software may load the local time of day; never sent down the chain.
// - master sends its time of day down the cable once per second.
// - tick counter upper at 0x0, lower at 0x8.
// - seconds at 0x100, nanoseconds at 0x108.
// - read-only status and control words at 0x10 and 0x110.
// - clear-on-sync clocks reset when the master synchronises the chain.
// - clock counts only when enabled; disabled clock holds or resets.
// - follow-cable clocks take the master's cable timebase when present.
// - master forwards cable clock only if enabled; slave reports following.
// - flag cable clock absent and cable clock stopped separately.
// - each clock independently started, stopped, isolated or connected.
// - report chain role: master, pass-through, final slave or isolated.
// - connected slave clocks stop while the master's cable clock is disabled.
`timescale 1ns/100ps
module ctb_timebase
   import ctb_pkg::*;
(
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   input  wire logic [AW-1:0] regAddr,
   input  wire logic [31:0]   regWrData,
   input  wire logic          regWr,
   input  wire logic          regRd,
   output logic      [31:0]   regRdData,
   input  wire ctb_cable_s    cableIn,
   output ctb_cable_s         cableOut
);
   logic          rstMeta, rstLocal;
   ctb_cable_s    cabMeta, cabSync, cabLast;
   logic [3:0]    tbCnt;
   logic          localTick, halfPoint;
   ctb_role_e     role;
   logic          cableEn, syncRefused;
   ctb_clk_ctrl_s tickCtrl, todCtrl;
   logic [63:0]   tickCount;
   logic [31:0]   todSec, todNs, tickLoSnap, todNsSnap;
   logic [5:0]    absentCnt;
   logic          cableTick, cableSyncEdge, cableAbsent, cableStopped, isSlave;
   logic          tickAdv, todAdv, chainSync, masterSyncReq, secRoll;
   logic [31:0]   nsSum;
   ctb_tx_e       txState;
   logic [63:0]   txShift;
   logic [6:0]    txCnt, rxCnt;
   logic [63:0]   rxShift, rxTime;
   logic          rxBusy, rxFresh;
   logic          wrChain;

   // picks the advance pulse of one clock from its control and the cable state
   function automatic logic pickTick(input ctb_clk_ctrl_s c, input logic slave,
                                     input logic absent, input logic stopped,
                                     input logic cTick, input logic lTick);
      if (!(c.follow && slave))
         pickTick = lTick;
      else if (stopped)
         pickTick = 1'b0;
      else if (absent)
         pickTick = lTick;
      else
         pickTick = cTick;
   endfunction

   // status word shared by both clocks
   function automatic logic [31:0] statusWord(input ctb_clk_ctrl_s c, input logic slave,
                                              input logic absent, input logic stopped,
                                              input logic en, input ctb_role_e r);
      logic following;
      following = c.follow && slave && !absent && !stopped;
      statusWord = '0;
      statusWord[3:0] = c;
      statusWord[ST_FOLLOW_BIT] = following;
      statusWord[ST_CABLE_BIT] = (r == ROLE_MASTER) ? en : following;
      statusWord[ST_ABSENT_BIT] = absent;
      statusWord[ST_STOP_BIT] = stopped;
      statusWord[ST_ROLE_LSB +: 2] = r;
   endfunction

   // reset release through two flip-flops
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta  <= 1'b0;
         rstLocal <= 1'b0;
      end else begin
         rstMeta  <= 1'b1;
         rstLocal <= rstMeta;
      end
   end

   // cable lines are asynchronous; only the second and third stages feed logic
   always_ff @(posedge ref_clk or negedge rstLocal) begin
      if (!rstLocal) begin
         cabMeta <= '0;
         cabSync <= '0;
         cabLast <= '0;
      end else begin
         cabMeta <= cableIn;
         cabSync <= cabMeta;
         cabLast <= cabSync;
      end
   end

   assign isSlave       = (role == ROLE_PASS) || (role == ROLE_FINAL);
   assign cableTick     = cabSync.clk && !cabLast.clk;
   assign cableSyncEdge = cabSync.sync && !cabLast.sync;
   assign cableStopped  = isSlave && !cabSync.run;
   assign cableAbsent   = isSlave && cabSync.run && (absentCnt == 6'(ABSENT_CYCLES));

   // edge watchdog; a running cable without edges counts as absent
   always_ff @(posedge ref_clk or negedge rstLocal) begin
      if (!rstLocal)
         absentCnt <= '0;
      else if (cableTick || !cabSync.run)
         absentCnt <= '0;
      else if (absentCnt != 6'(ABSENT_CYCLES))
         absentCnt <= absentCnt + 6'h01;
   end

   // local 400 ns divider, one-cycle tick enable
   always_ff @(posedge ref_clk or negedge rstLocal) begin
      if (!rstLocal)
         tbCnt <= '0;
      else if (tbCnt == 4'(TB_CYCLES - 1))
         tbCnt <= '0;
      else
         tbCnt <= tbCnt + 4'h1;
   end
   assign localTick = (tbCnt == 4'(TB_CYCLES - 1));
   assign halfPoint = (tbCnt == 4'(TB_HALF - 1));

   assign tickAdv = pickTick(tickCtrl, isSlave, cableAbsent, cableStopped, cableTick,
                             localTick);
   assign todAdv  = pickTick(todCtrl, isSlave, cableAbsent, cableStopped, cableTick,
                             localTick);
   assign wrChain = regWr && (regAddr == OFF_CHAIN);
   // a sync command is honoured on master or isolated boards only
   assign masterSyncReq = wrChain && regWrData[CH_SYNC_BIT] && !isSlave;
   assign chainSync = masterSyncReq || (isSlave && cableSyncEdge);

   // chain control and per-clock control registers
   always_ff @(posedge ref_clk or negedge rstLocal) begin
      if (!rstLocal) begin
         role        <= ROLE_ISOLATED;
         cableEn     <= 1'b0;
         syncRefused <= 1'b0;
         tickCtrl    <= CTRL_RESET;
         todCtrl     <= CTRL_RESET;
      end else begin
         if (wrChain) begin
            role    <= ctb_role_e'(regWrData[1:0]);
            cableEn <= regWrData[CH_EN_BIT];
         end
         // a refused sync sets the flag; setting wins over clearing
         if (wrChain && regWrData[CH_SYNC_BIT] && isSlave)
            syncRefused <= 1'b1;
         else if (wrChain && regWrData[CH_REFUSE_BIT])
            syncRefused <= 1'b0;
         if (regWr && regAddr == OFF_TICK_CTL)
            tickCtrl <= regWrData[3:0];
         if (regWr && regAddr == OFF_TOD_CTL)
            todCtrl <= regWrData[3:0];
      end
   end

   // tick counter: clear, count or hold only, never loaded
   always_ff @(posedge ref_clk or negedge rstLocal) begin
      if (!rstLocal)
         tickCount <= '0;
      else if (chainSync && tickCtrl.clrOnSync)
         tickCount <= '0;
      else if (!tickCtrl.enable) begin
         if (!tickCtrl.hold)
            tickCount <= '0;
      end else if (tickAdv)
         tickCount <= tickCount + 64'h1;
   end

   assign nsSum = todNs + NS_STEP;
   assign secRoll = todCtrl.enable && todAdv && (nsSum >= NS_PER_SEC);

   // seconds/nanoseconds clock; software loads are local to this board
   always_ff @(posedge ref_clk or negedge rstLocal) begin
      if (!rstLocal) begin
         todSec <= '0;
         todNs  <= '0;
      end else if (chainSync && todCtrl.clrOnSync) begin
         todSec <= '0;
         todNs  <= '0;
      end else if (regWr && (regAddr == OFF_TOD_SEC || regAddr == OFF_TOD_NS)) begin
         if (regAddr == OFF_TOD_SEC)
            todSec <= regWrData;
         else
            todNs <= regWrData;
      end else if (!todCtrl.enable) begin
         if (!todCtrl.hold) begin
            todSec <= '0;
            todNs  <= '0;
         end
      end else if (todAdv) begin
         if (nsSum >= NS_PER_SEC) begin
            todNs  <= nsSum - NS_PER_SEC;
            todSec <= todSec + 32'h1;
         end else
            todNs <= nsSum;
      end
   end

   // time frame sender: start bit then 64 bits, changed one ref_clk cycle before the clock's fall
   always_ff @(posedge ref_clk or negedge rstLocal) begin
      if (!rstLocal) begin
         txState <= TX_IDLE;
         txShift <= '0;
         txCnt   <= '0;
      end else begin
         case (txState)
            TX_IDLE: begin
               if (secRoll && role == ROLE_MASTER && cableEn) begin
                  txShift <= {todSec + 32'h1, nsSum - NS_PER_SEC};
                  txState <= TX_START;
               end
            end
            TX_START: begin
               if (halfPoint) begin
                  txState <= TX_DATA;
                  txCnt   <= '0;
               end
            end
            TX_DATA: begin
               if (halfPoint) begin
                  txShift <= {txShift[62:0], 1'b0};
                  txCnt   <= txCnt + 7'h01;
                  if (txCnt == 7'(FRAME_BITS))
                     txState <= TX_IDLE;
               end
            end
            default: txState <= TX_IDLE;
         endcase
      end
   end

   // cable outputs: master generates, pass-through forwards, others stay quiet
   always_ff @(posedge ref_clk or negedge rstLocal) begin
      if (!rstLocal)
         cableOut <= '0;
      else if (role == ROLE_MASTER) begin
         cableOut.run  <= cableEn;
         cableOut.clk  <= cableEn && (tbCnt < 4'(TB_HALF));
         cableOut.sync <= masterSyncReq || (cableOut.sync && !localTick);
         if (halfPoint)
            cableOut.data <= (txState == TX_START) ||
                             (txState == TX_DATA && txCnt != 7'(FRAME_BITS) &&
                              txShift[63]);
      end else if (role == ROLE_PASS)
         cableOut <= cabSync;
      else
         cableOut <= '0;
   end

   // time frame receiver on slaves, sampled at the cable clock's rise
   always_ff @(posedge ref_clk or negedge rstLocal) begin
      if (!rstLocal) begin
         rxBusy  <= 1'b0;
         rxCnt   <= '0;
         rxShift <= '0;
         rxTime  <= '0;
         rxFresh <= 1'b0;
      end else begin
         if (isSlave && cableTick) begin
            if (!rxBusy) begin
               rxBusy <= cabSync.data;
               rxCnt  <= '0;
            end else begin
               rxShift <= {rxShift[62:0], cabSync.data};
               rxCnt   <= rxCnt + 7'h01;
               if (rxCnt == 7'(FRAME_BITS - 1)) begin
                  rxBusy <= 1'b0;
                  rxTime <= {rxShift[62:0], cabSync.data};
               end
            end
         end
         // a frame landing while software clears the flag keeps it set
         if (isSlave && cableTick && rxBusy && rxCnt == 7'(FRAME_BITS - 1))
            rxFresh <= 1'b1;
         else if (regWr && regAddr == OFF_RX_ST && regWrData[0])
            rxFresh <= 1'b0;
      end
   end

   // read port: tick and time-of-day upper halves snapshot the lower halves for a coherent pair; received time is not snapshot
   always_ff @(posedge ref_clk or negedge rstLocal) begin
      if (!rstLocal) begin
         regRdData  <= '0;
         tickLoSnap <= '0;
         todNsSnap  <= '0;
      end else if (regRd) begin
         regRdData <= '0;
         case (regAddr)
            OFF_TICK_HI: begin
               regRdData  <= tickCount[63:32];
               tickLoSnap <= tickCount[31:0];
            end
            OFF_TICK_LO: regRdData <= tickLoSnap;
            OFF_TICK_ST: regRdData <= statusWord(tickCtrl, isSlave, cableAbsent,
                                                 cableStopped, cableEn, role);
            OFF_TOD_SEC: begin
               regRdData <= todSec;
               todNsSnap <= todNs;
            end
            OFF_TOD_NS:  regRdData <= todNsSnap;
            OFF_TOD_ST:  regRdData <= statusWord(todCtrl, isSlave, cableAbsent,
                                                 cableStopped, cableEn, role);
            OFF_CHAIN:   regRdData <= {23'h0, syncRefused, 5'h0, cableEn, role};
            OFF_TICK_CTL: regRdData <= {28'h0, tickCtrl};
            OFF_TOD_CTL: regRdData <= {28'h0, todCtrl};
            OFF_RX_SEC:  regRdData <= rxTime[63:32];
            OFF_RX_NS:   regRdData <= rxTime[31:0];
            OFF_RX_ST:   regRdData <= {31'h0, rxFresh};
            default:     regRdData <= '0;
         endcase
      end else
         regRdData <= '0;
   end

   // checks
   a_tick_steps_one: assert property (@(posedge ref_clk) disable iff (!rstLocal)
      $past(tickAdv) && $past(tickCtrl.enable) && !$past(chainSync)
      |-> tickCount == $past(tickCount) + 64'h1)
      else $error("tick counter did not step by one");
   a_tick_no_load: assert property (@(posedge ref_clk) disable iff (!rstLocal)
      tickCount == $past(tickCount) || tickCount == $past(tickCount) + 64'h1 ||
      tickCount == 64'h0)
      else $error("tick counter took a loaded value");
   a_tick_local_rate: assert property (@(posedge ref_clk) disable iff (!rstLocal)
      localTick && !isSlave |=> !localTick [*8] ##1 !localTick ##1 localTick)
      else $error("local timebase period is not ten cycles");
   a_ns_wrap: assert property (@(posedge ref_clk) disable iff (!rstLocal)
      secRoll && !chainSync && !(regWr && (regAddr == OFF_TOD_SEC || regAddr == OFF_TOD_NS))
      |=> todSec == $past(todSec) + 32'h1 && todNs == $past(nsSum) - NS_PER_SEC)
      else $error("nanosecond wrap or seconds carry wrong");
   a_sync_clears: assert property (@(posedge ref_clk) disable iff (!rstLocal)
      chainSync && tickCtrl.clrOnSync |=> tickCount == 64'h0)
      else $error("tick counter not cleared on chain sync");
   a_disabled_reset: assert property (@(posedge ref_clk) disable iff (!rstLocal)
      !tickCtrl.enable && !tickCtrl.hold |=> tickCount == 64'h0)
      else $error("disabled tick counter not reset");
   a_disabled_hold: assert property (@(posedge ref_clk) disable iff (!rstLocal)
      !tickCtrl.enable && tickCtrl.hold && !chainSync |=> $stable(tickCount))
      else $error("held tick counter moved");
   a_master_quiet: assert property (@(posedge ref_clk) disable iff (!rstLocal)
      role == ROLE_MASTER && !cableEn ##1 role == ROLE_MASTER |-> !cableOut.clk)
      else $error("cable clock driven while disabled");
   a_stop_freeze: assert property (@(posedge ref_clk) disable iff (!rstLocal)
      cableStopped && tickCtrl.follow && tickCtrl.enable && !chainSync
      |=> tickCount == $past(tickCount))
      else $error("connected tick counter ran with cable stopped");
   a_snap_pair: assert property (@(posedge ref_clk) disable iff (!rstLocal)
      regRd && regAddr == OFF_TICK_HI |=> tickLoSnap == $past(tickCount[31:0]))
      else $error("lower tick half not captured with upper read");
   a_pass_forward: assert property (@(posedge ref_clk) disable iff (!rstLocal)
      role == ROLE_PASS ##1 role == ROLE_PASS |-> cableOut == $past(cabSync))
      else $error("pass-through cable not forwarded");
   a_refuse_flag: assert property (@(posedge ref_clk) disable iff (!rstLocal)
      wrChain && regWrData[CH_SYNC_BIT] && isSlave |=> syncRefused)
      else $error("refused sync not flagged");
   a_rx_fresh_set: assert property (@(posedge ref_clk) disable iff (!rstLocal)
      isSlave && cableTick && rxBusy && rxCnt == 7'(FRAME_BITS - 1) |=> rxFresh)
      else $error("received frame did not raise the fresh flag");
endmodule

// [testbench/ctb_upstream.sv]
// upstream board model: drives the chain cable into the block
// assumes the bench calls its tasks; runs on its own 320 ns timebase
`timescale 1ns/100ps
module ctb_upstream
   import ctb_pkg::*;
(
   output ctb_cable_s cable
);
   // idle cable: stopped, no sync, data low
   initial begin
      cable = '0;
   end
   // timebase periods; the odd split keeps rising edges off the ref_clk grid
   task automatic tick(input int n);
      repeat (n) begin
         #163 cable.clk = 1'b1;
         #157 cable.clk = 1'b0;
      end
   endtask
   // cable signal enable of the upstream master
   task automatic setRun(input logic r);
      cable.run = r;
   endtask
   // start bit then 64 bits msb first; data moves only while clk is low
   task automatic frame(input logic [63:0] v);
      cable.data = 1'b1;
      tick(1);
      for (int i = 63; i >= 0; i--) begin
         cable.data = v[i];
         tick(1);
      end
      cable.data = 1'b0;
   endtask
   // chain sync as a rising level held over two periods
   task automatic syncPulse();
      cable.sync = 1'b1;
      tick(2);
      cable.sync = 1'b0;
   endtask
endmodule

// [testbench/ctb_timebase_test.sv]
// bench for the chained timebase: register tasks, cable model, checks
// assumes ctb_upstream drives cableIn; registers answer one cycle late
`timescale 1ns/100ps
module ctb_timebase_test;
   import ctb_pkg::*;
   logic          ref_clk;
   logic          rst_n;
   logic [AW-1:0] regAddr;
   logic [31:0]   regWrData;
   logic          regWr;
   logic          regRd;
   logic [31:0]   regRdData;
   ctb_cable_s    cableIn;
   ctb_cable_s    cableOut;
   logic [31:0]   w;
   logic [31:0]   x;
   logic [63:0]   v;
   int            k;
   int            num_errors;
   int            checked;

   ctb_timebase uut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .cableIn(cableIn), .cableOut(cableOut));
   ctb_upstream up (.cable(cableIn));

   // 25 MHz reference clock
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic summarize();
      $display("checked %0d, errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [AW-1:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask
   task automatic rdChk(input logic [AW-1:0] a, input logic [31:0] e, input string what);
      logic [31:0] d;
      rd(a, d);
      chk(d, e, what);
   endtask
   // upper read latches the lower half, so this pair is one snapshot
   task automatic rdTick(output logic [63:0] t);
      rd(OFF_TICK_HI, t[63:32]);
      rd(OFF_TICK_LO, t[31:0]);
   endtask
   // tick advance over exactly 100 cycles between the two upper reads
   task automatic span(output logic [63:0] d);
      logic [63:0] a;
      logic [63:0] b;
      rdTick(a);
      waitc(96);
      rdTick(b);
      d = b - a;
   endtask
   task automatic rdNs(output logic [31:0] d);
      rd(OFF_TOD_SEC, d);
      rd(OFF_TOD_NS, d);
   endtask
   task automatic countRise(input int n, output int c);
      logic p;
      // first sample after the edge settles, so exactly n cycles are compared
      #1;
      p = cableOut.clk;
      c = 0;
      repeat (n) begin
         @(posedge ref_clk);
         #1;
         if (cableOut.clk && !p) c++;
         p = cableOut.clk;
      end
   endtask
   // waits for a start bit at a cable clk rise, then shifts in 64 bits
   task automatic grab(output logic [63:0] f);
      logic p;
      int   i;
      int   n;
      p = 1'b1;
      i = -1;
      n = 0;
      f = '0;
      while (i < 64) begin
         @(posedge ref_clk);
         #1;
         if (cableOut.clk && !p && (i >= 0 || cableOut.data)) begin
            if (i >= 0) f = {f[62:0], cableOut.data};
            i++;
         end
         p = cableOut.clk;
         n++;
         if (n > 2000) begin
            num_errors++;
            $display("Error at %0t: no frame on the cable", $time);
            summarize();
         end
      end
   endtask

   // main sequence
   initial begin
      {regWr, regRd, rst_n} = 3'h0;
      regAddr = '0;
      regWrData = '0;
      num_errors = 0;
      checked = 0;
      waitc(4);
      rst_n <= 1'b1;
      waitc(4);
      rdChk(OFF_CHAIN, 32'h3, "role");
      rdChk(OFF_TICK_CTL, 32'h1, "tick ctl");
      rdChk(OFF_TOD_CTL, 32'h1, "tod ctl");
      rdChk(12'h300, 32'h0, "hole");
      chk(cableOut, 4'h0, "isolated cable");
      $display("test reset done");
      wr(OFF_CHAIN, 32'h0);
      span(v);
      chk(v, 64'hA, "ticks per 100 cycles");
      chk(cableOut, 4'h0, "cable off");
      wr(OFF_TICK_HI, 32'hFFFF_FFFF);
      rdChk(OFF_TICK_HI, 32'h0, "tick load");
      wr(OFF_TICK_ST, 32'h0);
      rd(OFF_TICK_ST, w);
      chk({w[13:12], w[3:0]}, 6'h01, "tick status");
      wr(OFF_TOD_ST, 32'h0);
      rd(OFF_TOD_ST, w);
      chk({w[13:12], w[3:0]}, 6'h01, "tod status");
      $display("test master local done");
      wr(OFF_TOD_SEC, 32'h5);
      wr(OFF_TOD_NS, 32'h3B9A_C3C0);
      waitc(98);
      rdChk(OFF_TOD_SEC, 32'h6, "sec carry");
      rd(OFF_TOD_NS, w);
      chk(w == 32'd2400 || w == 32'd2000, 1'b1, "ns wrap");
      wr(OFF_TOD_CTL, 32'h8);
      rdNs(x);
      span(v);
      rdNs(w);
      chk(w, x, "hold when stopped");
      chk(v, 64'hA, "tick independent");
      wr(OFF_TICK_CTL, 32'h8);
      span(v);
      chk(v, 64'h0, "tick held");
      rdTick(v);
      chk(v > 64'h10, 1'b1, "tick kept");
      wr(OFF_TOD_CTL, 32'h0);
      rdChk(OFF_TOD_SEC, 32'h0, "reset when stopped");
      wr(OFF_TOD_CTL, 32'h1);
      wr(OFF_TICK_CTL, 32'h0);
      rdTick(v);
      chk(v, 64'h0, "tick stopped");
      $display("test stop done");
      wr(OFF_TICK_CTL, 32'h3);
      waitc(50);
      wr(OFF_CHAIN, 32'h8);
      for (k = 0; k < 30 && !cableOut.sync; k++) waitc(1);
      chk(cableOut.sync, 1'b1, "sync out");
      waitc(10);
      rdTick(v);
      chk(v < 5, 1'b1, "sync clear");
      wr(OFF_CHAIN, 32'h4);
      waitc(20);
      countRise(100, k);
      chk(k, 64'hA, "cable clk");
      chk(cableOut.run, 1'b1, "cable run");
      wr(OFF_TOD_SEC, 32'h7);
      wr(OFF_TOD_NS, 32'h3B9A_BA60);
      grab(v);
      chk(v, {32'h8, 32'h0}, "time frame");
      $display("test master cable done");
      wr(OFF_CHAIN, 32'h2);
      wr(OFF_TICK_CTL, 32'h5);
      up.setRun(1'b1);
      fork
         up.tick(80);
         begin
            waitc(30);
            span(v);
            rd(OFF_TICK_ST, w);
         end
      join
      chk(v == 12 || v == 13, 1'b1, "follow cable");
      chk({w[13:12], w[8], w[4]}, 4'hB, "slave status");
      up.setRun(1'b0);
      waitc(20);
      rd(OFF_TICK_ST, w);
      chk(w[10], 1'b1, "stopped flag");
      span(v);
      chk(v, 64'h0, "frozen");
      up.setRun(1'b1);
      waitc(60);
      rd(OFF_TICK_ST, w);
      chk(w[10:9], 2'h1, "absent flag");
      up.frame(64'h0000_0009_0000_0190);
      rdChk(OFF_RX_SEC, 32'h9, "rx sec");
      rdChk(OFF_RX_NS, 32'h190, "rx ns");
      rd(OFF_RX_ST, w);
      chk(w[0], 1'b1, "rx fresh");
      wr(OFF_TICK_CTL, 32'h7);
      up.syncPulse();
      rdTick(v);
      chk(v < 5, 1'b1, "slave sync");
      wr(OFF_CHAIN, 32'hA);
      rd(OFF_CHAIN, w);
      chk(w[8], 1'b1, "sync refused");
      wr(OFF_CHAIN, 32'h1);
      fork
         up.tick(20);
         countRise(200, k);
      join
      chk(k, 64'h14, "pass clk");
      chk(cableOut.run, 1'b1, "pass run");
      rd(OFF_TOD_ST, w);
      chk(w[13:12], 2'h1, "pass role");
      $display("test slave done");
      summarize();
   end
endmodule
